// file: tap_window_pkg.sv
/*
 * constants and types shared by the double tap window timer.
 * assumes a 200 MHz ref_clk and register writes arriving as plain strobes.
 */
package tap_window_pkg;

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    localparam logic [7:0] WINDOW_RESET = 8'h00;
    localparam logic [7:0] LATENCY_RESET = 8'h00;
    localparam logic [7:0] TIME_LIMIT_RESET = 8'h00;

    // ------------------------------------------------------------
    // rate and power mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] RATE_800 = 3'h0;
    localparam logic [2:0] RATE_400 = 3'h1;
    localparam logic [2:0] RATE_200 = 3'h2;
    localparam logic [2:0] RATE_100 = 3'h3;
    localparam logic [2:0] RATE_50 = 3'h4;
    localparam logic [2:0] RATE_12P5 = 3'h5;
    localparam logic [2:0] RATE_6P25 = 3'h6;
    localparam logic [2:0] RATE_1P56 = 3'h7;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_LOW_POWER_LOW_NOISE = 2'h1,
        MODE_HIGH_RES = 2'h2,
        MODE_LOW_POWER = 2'h3
    } power_mode_type;

    // ------------------------------------------------------------
    // timing: shortest step 1.25 ms, steps are powers of two of it
    // ------------------------------------------------------------
    localparam int BASE_STEP_NS = 1250000;
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int BASE_STEP_CYCLES = BASE_STEP_NS / CLOCK_PERIOD_NS;
    localparam int STEP_CNT_WIDTH = 26;
    localparam logic [3:0] MAX_SHIFT_FILTERED = 4'h8;

endpackage : tap_window_pkg

// file: tap_step_timer.sv
/*
 * step timer: emits a one-cycle tick every time step of the selected length.
 * assumes the step exponent is stable while a window runs; restart realigns.
 */
`timescale 1ns/1ps
module tap_step_timer #(
    parameter int BASE_CYCLES = tap_window_pkg::BASE_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic restart,
    input wire logic [3:0] step_shift,
    output logic tick
);
    import tap_window_pkg::*;

    typedef struct packed {
        logic [STEP_CNT_WIDTH-1:0] count;
        logic tick;
    } timer_state_type;

    timer_state_type state;
    timer_state_type next_state;
    logic [STEP_CNT_WIDTH-1:0] limit;

    // ------------------------------------------------------------
    // step length = base step << shift
    // ------------------------------------------------------------
    always_comb begin
        limit = STEP_CNT_WIDTH'(BASE_CYCLES) << step_shift;
        next_state = state;
        next_state.tick = 1'b0;
        if (restart) begin
            next_state.count = '0;
        end else if (state.count >= limit - STEP_CNT_WIDTH'(1)) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + STEP_CNT_WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : tap_step_timer

// file: double_tap_window_timer.sv
/*
 * double tap window timer: latency, window and second-pulse qualification.
 * assumes pulse start/end from the threshold logic on ref_clk and register
 * writes presented as a value with a one-cycle write strobe.
 */
`timescale 1ns/1ps
module double_tap_window_timer #(
    parameter int BASE_CYCLES = tap_window_pkg::BASE_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic window_write,
    input wire logic [7:0] window_write_data,
    input wire logic [7:0] latency,
    input wire logic [7:0] time_limit,
    input wire logic double_enable,
    input wire logic highpass_filter_enable,
    input wire logic [2:0] output_sample_rate,
    input wire tap_window_pkg::power_mode_type power_mode,
    input wire logic pulse_start,
    input wire logic pulse_end,
    output logic [7:0] double_tap_window,
    output logic latency_end,
    output logic window_open,
    output logic pulse_time_limit,
    output logic double_tap_detected,
    output logic window_expired
);
    import tap_window_pkg::*;

    typedef enum logic [2:0] {
        IDLE,
        FIRST_PULSE,
        LATENCY,
        WINDOW,
        SECOND_PULSE
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic [7:0] window;
        logic [7:0] count;
        logic latency_end;
        logic window_open;
        logic limit_hit;
        logic detected;
        logic expired;
    } tap_state_type;

    tap_state_type state;
    tap_state_type next_state;
    logic [3:0] shift;
    logic tick;
    logic restart;

    // ------------------------------------------------------------
    // time step selection
    // ------------------------------------------------------------
    function automatic logic [3:0] window_shift(input logic [2:0] rate, input power_mode_type mode,
                                                input logic filtered);
        logic [3:0] fast;
        logic [3:0] s;
        fast = (rate >= RATE_12P5) ? 4'h5 : {1'b0, rate} + 4'h1;
        case (mode)
            MODE_HIGH_RES: begin
                s = (rate == RATE_800) ? 4'h1 : 4'h2;
            end
            MODE_LOW_POWER_LOW_NOISE: begin
                s = (rate >= RATE_12P5) ? 4'h7 : fast;
            end
            MODE_LOW_POWER: begin
                s = (rate >= RATE_6P25) ? MAX_SHIFT_FILTERED : ((rate >= RATE_12P5) ? 4'h7 : fast);
            end
            default: begin
                s = fast;
            end
        endcase
        if (!filtered) begin
            if (mode == MODE_LOW_POWER) begin
                s = (s > 4'h7) ? 4'h6 : s - 4'h1;
            end else begin
                s = (s > 4'h2) ? s - 4'h2 : 4'h0;
            end
        end
        return s;
    endfunction : window_shift

    // ------------------------------------------------------------
    // step count check shared by latency and pulse limit
    // ------------------------------------------------------------
    function automatic logic steps_reached(input logic [7:0] steps, input logic [7:0] limit);
        return steps + 8'h01 >= limit;
    endfunction : steps_reached

    assign shift = window_shift(output_sample_rate, power_mode, highpass_filter_enable);

    // ------------------------------------------------------------
    // step timer
    // ------------------------------------------------------------
    tap_step_timer #(
        .BASE_CYCLES(BASE_CYCLES)
    ) step_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(restart),
        .step_shift(shift),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // detection sequence
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.latency_end = 1'b0;
        next_state.limit_hit = 1'b0;
        next_state.detected = 1'b0;
        next_state.expired = 1'b0;
        restart = 1'b0;
        if (window_write) begin
            next_state.window = window_write_data;
        end
        case (state.phase)
            IDLE: begin
                if (pulse_start && double_enable) begin
                    next_state.phase = FIRST_PULSE;
                    next_state.count = '0;
                    restart = 1'b1;
                end
            end
            FIRST_PULSE: begin
                if (pulse_end) begin
                    next_state.phase = LATENCY;
                    next_state.count = '0;
                    restart = 1'b1;
                end else if (tick) begin
                    if (steps_reached(state.count, time_limit)) begin
                        next_state.phase = IDLE;
                        next_state.limit_hit = 1'b1;
                    end else begin
                        next_state.count = state.count + 8'h01;
                    end
                end
            end
            LATENCY: begin
                if (latency == 8'h00 || (tick && steps_reached(state.count, latency))) begin
                    next_state.phase = WINDOW;
                    next_state.count = next_state.window;
                    next_state.latency_end = 1'b1;
                    next_state.window_open = 1'b1;
                    restart = 1'b1;
                end else if (tick) begin
                    next_state.count = state.count + 8'h01;
                end
            end
            WINDOW: begin
                if (pulse_start) begin
                    next_state.phase = SECOND_PULSE;
                    next_state.window_open = 1'b0;
                    next_state.count = '0;
                    restart = 1'b1;
                end else if (state.count == 8'h00) begin
                    next_state.phase = IDLE;
                    next_state.window_open = 1'b0;
                    next_state.expired = 1'b1;
                end else if (tick) begin
                    next_state.count = state.count - 8'h01;
                end
            end
            SECOND_PULSE: begin
                if (pulse_end) begin
                    next_state.phase = IDLE;
                    next_state.detected = 1'b1;
                end else if (tick) begin
                    if (steps_reached(state.count, time_limit)) begin
                        next_state.phase = IDLE;
                        next_state.limit_hit = 1'b1;
                    end else begin
                        next_state.count = state.count + 8'h01;
                    end
                end
            end
            default: begin
                next_state.phase = IDLE;
            end
        endcase
        if (!double_enable) begin
            next_state.phase = IDLE;
            next_state.window_open = 1'b0;
            next_state.latency_end = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
            state.window <= WINDOW_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign double_tap_window = state.window;
    assign latency_end = state.latency_end;
    assign window_open = state.window_open;
    assign pulse_time_limit = state.limit_hit;
    assign double_tap_detected = state.detected;
    assign window_expired = state.expired;

endmodule : double_tap_window_timer

// file: double_tap_window_timer_sva.sv
/* checks on the double tap window timer ports.
   assumes binding onto double_tap_window_timer. */
`timescale 1ns/1ps
module double_tap_window_timer_sva (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic window_write,
    input wire logic [7:0] window_write_data,
    input wire logic double_enable,
    input wire logic pulse_start,
    input wire logic [7:0] double_tap_window,
    input wire logic latency_end,
    input wire logic window_open,
    input wire logic double_tap_detected,
    input wire logic window_expired
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_open;
        latency_end ##0 window_open;
    endsequence
    AST_WR_LOAD: assert property (window_write |=> double_tap_window == $past(window_write_data))
        else $error("window load wrong");
    AST_WR_HOLD: assert property (!window_write |=> $stable(double_tap_window))
        else $error("window value moved");
    AST_OPEN_AT_END: assert property ($rose(window_open) |-> latency_end)
        else $error("window opened early");
    AST_END_OPENS: assert property (latency_end && double_enable |-> window_open)
        else $error("latency end without window");
    AST_ZERO_EXPIRES: assert property (s_open ##0 (double_tap_window == 8'h00 && !pulse_start) |=> window_expired)
        else $error("zero window kept open");
    AST_DISABLE_IDLE: assert property (!double_enable [*2] |-> !window_open && !latency_end)
        else $error("active while disabled");
    AST_DET_SINGLE: assert property (double_tap_detected |=> !double_tap_detected)
        else $error("detect not a pulse");
    AST_EXPIRE_CLOSES: assert property (window_expired |-> $past(window_open) && !window_open)
        else $error("expiry without window");
    AST_NO_BOTH: assert property (!(double_tap_detected && window_expired))
        else $error("detect and expiry together");
endmodule : double_tap_window_timer_sva
bind double_tap_window_timer double_tap_window_timer_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
    .window_write(window_write), .window_write_data(window_write_data), .double_enable(double_enable),
    .pulse_start(pulse_start), .double_tap_window(double_tap_window), .latency_end(latency_end),
    .window_open(window_open), .double_tap_detected(double_tap_detected), .window_expired(window_expired));

// file: double_tap_window_timer_tb_top.sv
/* self-checking bench for the double tap window timer.
   assumes BASE_CYCLES of 4; every power mode is driven, rates are drawn at random. */
`timescale 1ns/1ps
module double_tap_window_timer_tb_top;
    import tap_window_pkg::*;
    localparam int BASE = 4;
    logic ref_clk = 0, resetn = 0, wr = 0, en = 1, hpf = 0, ps = 0, pe = 0;
    logic [7:0] wd = 0, lat = 1, tl = 0, dtw;
    logic [2:0] rate = 0;
    power_mode_type pm = MODE_NORMAL;
    logic le, wo, ptl, det, wx;
    int mismatches = 0, n_tests = 0, cycles = 0, st, w, n;
    always #2.5 ref_clk = ~ref_clk;
    double_tap_window_timer #(.BASE_CYCLES(BASE)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .window_write(wr),
        .window_write_data(wd), .latency(lat), .time_limit(tl), .double_enable(en), .highpass_filter_enable(hpf),
        .output_sample_rate(rate), .power_mode(pm), .pulse_start(ps), .pulse_end(pe), .double_tap_window(dtw),
        .latency_end(le), .window_open(wo), .pulse_time_limit(ptl), .double_tap_detected(det), .window_expired(wx));
    task print_verdict;
        $display("mismatches %0d tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            print_verdict();
        end
    end
    task chk(logic [31:0] g, logic [31:0] lo, logic [31:0] hi);
        n_tests++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h..%h", $time, g, lo, hi);
        end
    endtask : chk
    task tick(int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick
    function logic ev(int s);
        case (s)
            0: return le;
            1: return wx;
            2: return det;
            default: return ptl;
        endcase
    endfunction : ev
    task wait_ev(int s, int lim);
        n = 0;
        while (ev(s) !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_ev
    task strobe(int e);
        if (e) pe = 1;
        else ps = 1;
        tick(1);
        ps = 0;
        pe = 0;
    endtask : strobe
    task first_tap;
        strobe(0);
        tick(1);
        strobe(1);
    endtask : first_tap
    // model: step length in cycles, with BASE cycles standing for one 1.25 ms base step
    function int step_of(int r, power_mode_type m, logic f);
        int u;
        case ({f, m})
            3'b100: u = (r > 4) ? 32 : 2 << r;
            3'b101: u = (r > 4) ? 128 : 2 << r;
            3'b110: u = (r == 0) ? 2 : 4;
            3'b111: u = (r > 5) ? 256 : ((r > 4) ? 128 : 2 << r);
            3'b000: u = (r < 2) ? 1 : ((r > 4) ? 8 : 1 << (r - 1));
            3'b001: u = (r < 2) ? 1 : ((r > 4) ? 32 : 1 << (r - 1));
            3'b010: u = 1;
            default: u = (r > 4) ? 64 : 1 << r;
        endcase
        return BASE * u;
    endfunction : step_of
    task put_window(int v);
        wd = 8'(v);
        wr = 1;
        tick(1);
        wr = 0;
        chk(dtw, v, v);
    endtask : put_window
    initial begin
        void'($urandom(32'h1129));
        tick(4);
        resetn = 1;
        tick(1);
        chk(dtw, 0, 0);
        for (int i = 0; i < 6; i++) begin
            rate = 3'($urandom % 5);
            pm = power_mode_type'(2'($urandom % 4));
            hpf = 1'($urandom % 2);
            w = 1 + $urandom % 3;
            st = step_of(rate, pm, hpf);
            tl = 8'(w + 2);
            put_window(w);
            first_tap();
            strobe(0);
            wait_ev(0, 4 * st);
            chk(n, st - 3, st + 2);
            chk(wo, 1, 1);
            wait_ev(1, 4 * w * st);
            chk(n, w * st - 1, w * st + 2);
            chk(wo, 0, 0);
            first_tap();
            wait_ev(0, 4 * st);
            strobe(0);
            tick(w * st + 2);
            strobe(1);
            wait_ev(2, 4);
            chk(n, 0, 3);
            first_tap();
            wait_ev(0, 4 * st);
            strobe(0);
            wait_ev(3, tl * st + 4);
            chk(n, tl * st - 3, tl * st + 2);
            strobe(1);
            wait_ev(2, 4);
            chk(n, 4, 4);
        end
        put_window(0);
        for (int i = 0; i < 8; i++) begin
            rate = 3'(5 + $urandom % 3);
            pm = power_mode_type'(2'(i));
            hpf = 1'(i / 4);
            st = step_of(rate, pm, hpf);
            first_tap();
            wait_ev(0, 2 * st);
            chk(n, st, st + 2);
            wait_ev(1, 4);
            chk(n, 0, 2);
        end
        en = 0;
        first_tap();
        wait_ev(0, 8 * st);
        chk(n, 8 * st, 8 * st);
        print_verdict();
    end
endmodule : double_tap_window_timer_tb_top
